// ---- design/sla_arbiter_timer.v ----
// serial line arbiter and bit timer with an AXI4-Lite register slave
//
// Local design decisions: the AXI4-Lite register port and the address map.
`include "sla_defines.vh"

// Function
// - nine-bit up-counter with separate overflow bit
// - two-bit mode: idle, measure, arbitrate, reserved
// - reset clears mode, clock select, flags, counter
// - lost flag read-only, cleared writing upper mode 0
// - clock select: prescaler quarter or bus quarter
// - prescaler input picked by configuration bit
// - done flag on finish, cleared by control write
// - running flag shows counter counting
// - overflow flag on wrap, cleared by control write
// - msb in control, low byte in data; control write clears
// - idle mode holds counter cleared
// - bus source: run between two receive falling edges
// - prescaler source: run while receive low till rise
// - arbitration restarts counter on transmit rising edge
// - sample receive at 38h or 08h; low sets lost
// - lost forces external transmit pin high
// - transmit low before any sensed low resets counter
module sla_arbiter_timer (
  input wire clock, // 50 MHz system clock
  input wire arst_n, // asynchronous reset, active low
  input wire [3:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output wire s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte strobes
  input wire s_axi_wvalid, // write data valid
  output wire s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [3:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output wire s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire rxdIn, // receive line level
  input wire internalTransmitOut, // transmit level from the serial module
  input wire prescalerSourceSelect, // configuration bit: 1 oscillator, 0 bus clock
  input wire busPrescalerTick, // prescaler output pulse when fed by bus clock
  input wire oscPrescalerTick, // prescaler output pulse when fed by oscillator clock
  output wire txdPin, // external transmit pin level
  output wire irq // level interrupt, high while unmasked status set
);

  // combinational address decode shared by both channels
  function [1:0] regIndex;
    input [3:0] addr;
    begin
      regIndex = addr[3:2];
    end
  endfunction

  reg [1:0] modeQ;
  reg clkSelQ;
  reg lostQ;
  reg doneQ;
  reg runQ;
  reg ovfQ;
  reg [8:0] cntQ;
  reg smpQ;
  reg [1:0] divQ;
  reg rxPrevQ;
  reg txPrevQ;
  reg [2:0] irqStatQ;
  reg [2:0] irqMaskQ;

  reg awHaveQ;
  reg wHaveQ;
  reg [3:0] awAddrQ;
  reg [31:0] wDataQ;
  reg [3:0] wStrbQ;

  reg [1:0] mode_d;
  reg clkSel_d;
  reg lost_d;
  reg done_d;
  reg run_d;
  reg ovf_d;
  reg [8:0] cnt_d;
  reg smp_d;
  reg doneSet;
  reg ovfSet;
  reg lostSet;

  wire doWrite;
  wire ctrlWr;
  wire baseTick;
  wire quarterTick;
  wire rxFall;
  wire rxRise;
  wire txRise;
  wire txFall;
  wire [9:0] cntInc;
  wire [8:0] samplePoint;
  wire [7:0] ctrlRead;
  wire wrStat;
  wire wrMask;

  // both halves of a write are held until the slave can answer
  assign s_axi_awready = !awHaveQ && !s_axi_bvalid;
  assign s_axi_wready = !wHaveQ && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign doWrite = awHaveQ && wHaveQ && !s_axi_bvalid;
  assign ctrlWr = doWrite && (regIndex(awAddrQ) == regIndex(`SLA_ADDR_CTRL)) && wStrbQ[0];
  assign wrStat = doWrite && (regIndex(awAddrQ) == regIndex(`SLA_ADDR_IRQ_STAT)) && wStrbQ[0];
  assign wrMask = doWrite && (regIndex(awAddrQ) == regIndex(`SLA_ADDR_IRQ_MASK)) && wStrbQ[0];

  // counter clock source and divide-by-four
  assign baseTick = clkSelQ ? (prescalerSourceSelect ? oscPrescalerTick : busPrescalerTick)
    : 1'b1;
  assign quarterTick = baseTick && (divQ == 2'h3);

  assign rxFall = rxPrevQ && !rxdIn;
  assign rxRise = !rxPrevQ && rxdIn;
  assign txRise = !txPrevQ && internalTransmitOut;
  assign txFall = txPrevQ && !internalTransmitOut;
  assign cntInc = {1'b0, cntQ} + 10'h001;
  assign samplePoint = clkSelQ ? `SLA_SAMPLE_PRE : `SLA_SAMPLE_BUS;

  assign txdPin = lostQ ? 1'b1 : internalTransmitOut;
  assign irq = |(irqStatQ & irqMaskQ);

  assign ctrlRead = {modeQ, lostQ, clkSelQ, doneQ, runQ, ovfQ, cntQ[8]};

  always @*
  begin
    mode_d = modeQ;
    clkSel_d = clkSelQ;
    run_d = runQ;
    cnt_d = cntQ;
    smp_d = smpQ;
    doneSet = 1'b0;
    ovfSet = 1'b0;
    lostSet = 1'b0;
    // counting happens before any start, stop or restart overrides it
    if (runQ && quarterTick)
    begin
      cnt_d = cntInc[8:0];
      ovfSet = cntInc[9];
    end
    case (modeQ)
      `SLA_MODE_MEASURE:
      begin
        if (!clkSelQ)
        begin
          if (rxFall && !doneQ)
          begin
            if (!runQ)
            begin
              run_d = 1'b1;
            end
            else
            begin
              run_d = 1'b0;
              doneSet = 1'b1;
            end
          end
        end
        else
        begin
          // level start, so a line already low starts at once
          if (!runQ && !doneQ && !rxdIn)
          begin
            run_d = 1'b1;
          end
          else if (runQ && rxRise)
          begin
            run_d = 1'b0;
            doneSet = 1'b1;
          end
        end
      end
      `SLA_MODE_ARB:
      begin
        if (!lostQ)
        begin
          if (txRise)
          begin
            cnt_d = `SLA_RST_COUNT;
            run_d = 1'b1;
            smp_d = 1'b0;
            ovfSet = 1'b0;
          end
          else if (txFall)
          begin
            // waits for the next rising transmit edge to resume
            cnt_d = `SLA_RST_COUNT;
            run_d = 1'b0;
            smp_d = 1'b0;
            ovfSet = 1'b0;
          end
          else if (runQ && !smpQ && cntQ == samplePoint)
          begin
            smp_d = 1'b1;
            if (!rxdIn)
            begin
              lostSet = 1'b1;
              run_d = 1'b0;
            end
          end
        end
      end
      default:
      begin
        // idle and the reserved code both park the counter
        cnt_d = `SLA_RST_COUNT;
        run_d = 1'b0;
        smp_d = 1'b0;
        ovfSet = 1'b0;
      end
    endcase
    if (ctrlWr)
    begin
      mode_d = {wDataQ[`SLA_CTRL_MODE_HI], wDataQ[`SLA_CTRL_MODE_LO]};
      clkSel_d = wDataQ[`SLA_CTRL_CLKSEL];
      cnt_d = `SLA_RST_COUNT;
      run_d = 1'b0;
      smp_d = 1'b0;
    end
    // a flag set in the cycle of its clear survives
    done_d = (doneQ && !ctrlWr) || doneSet;
    ovf_d = (ovfQ && !ctrlWr) || ovfSet;
    lost_d = (lostQ && !(ctrlWr && !wDataQ[`SLA_CTRL_MODE_HI])) || lostSet;
  end

  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      modeQ <= `SLA_RST_MODE;
      clkSelQ <= 1'b0;
      lostQ <= 1'b0;
      doneQ <= 1'b0;
      runQ <= 1'b0;
      ovfQ <= 1'b0;
      cntQ <= `SLA_RST_COUNT;
      smpQ <= 1'b0;
      rxPrevQ <= 1'b1;
      txPrevQ <= 1'b1;
    end
    else
    begin
      modeQ <= mode_d;
      clkSelQ <= clkSel_d;
      lostQ <= lost_d;
      doneQ <= done_d;
      runQ <= run_d;
      ovfQ <= ovf_d;
      cntQ <= cnt_d;
      smpQ <= smp_d;
      rxPrevQ <= rxdIn;
      txPrevQ <= internalTransmitOut;
    end
  end

  // divider restarts with the counter so the first step is a full quarter
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      divQ <= 2'h0;
    end
    else
    begin
      if (ctrlWr || !runQ)
      begin
        divQ <= 2'h0;
      end
      else if (baseTick)
      begin
        divQ <= divQ + 2'h1;
      end
    end
  end

  // write channel: address and data may arrive in either order
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      awHaveQ <= 1'b0;
      wHaveQ <= 1'b0;
      awAddrQ <= 4'h0;
      wDataQ <= 32'h00000000;
      wStrbQ <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SLA_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHaveQ <= 1'b1;
        awAddrQ <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHaveQ <= 1'b1;
        wDataQ <= s_axi_wdata;
        wStrbQ <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awHaveQ <= 1'b0;
        wHaveQ <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `SLA_RESP_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // interrupt mask and sticky status
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irqStatQ <= 3'h0;
      irqMaskQ <= `SLA_RST_MASK;
    end
    else
    begin
      if (wrMask)
      begin
        irqMaskQ <= wDataQ[2:0];
      end
      // hardware events win over a write-one clear in the same cycle
      if (wrStat)
      begin
        irqStatQ <= (irqStatQ & ~wDataQ[2:0]) | {lostSet, ovfSet, doneSet};
      end
      else
      begin
        irqStatQ <= irqStatQ | {lostSet, ovfSet, doneSet};
      end
    end
  end

  // read channel: answer is registered, so a new address waits for rready
  always @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `SLA_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `SLA_RESP_OKAY;
        case (regIndex(s_axi_araddr))
          2'h0: s_axi_rdata <= {24'h000000, ctrlRead};
          2'h1: s_axi_rdata <= {24'h000000, cntQ[7:0]};
          2'h2: s_axi_rdata <= {29'h00000000, irqStatQ};
          default: s_axi_rdata <= {29'h00000000, irqMaskQ};
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // sla_arbiter_timer

// ---- design/sla_defines.vh ----
// register map, field positions, reset values and timing constants of the arbiter timer
`ifndef SLA_DEFINES_VH
`define SLA_DEFINES_VH

// byte addresses on the register bus
`define SLA_ADDR_CTRL 4'h0
`define SLA_ADDR_COUNT 4'h4
`define SLA_ADDR_IRQ_STAT 4'h8
`define SLA_ADDR_IRQ_MASK 4'hC

// arbiter_control_status fields
`define SLA_CTRL_MODE_HI 7
`define SLA_CTRL_MODE_LO 6
`define SLA_CTRL_LOST 5
`define SLA_CTRL_CLKSEL 4
`define SLA_CTRL_DONE 3
`define SLA_CTRL_RUN 2
`define SLA_CTRL_OVF 1
`define SLA_CTRL_MSB 0

// mode codes
`define SLA_MODE_IDLE 2'h0
`define SLA_MODE_MEASURE 2'h1
`define SLA_MODE_ARB 2'h2
`define SLA_MODE_RSVD 2'h3

// interrupt status / mask fields
`define SLA_IRQ_DONE 0
`define SLA_IRQ_OVF 1
`define SLA_IRQ_LOST 2

// reset values
`define SLA_RST_MODE 2'h0
`define SLA_RST_COUNT 9'h000
`define SLA_RST_MASK 3'h0

// counter clock divides its source by this figure
`define SLA_TICK_DIV 3'h4
// arbitration sample points, bus clock source and prescaler source
`define SLA_SAMPLE_BUS 9'h038
`define SLA_SAMPLE_PRE 9'h008

// bus responses
`define SLA_RESP_OKAY 2'h0
`define SLA_RESP_SLVERR 2'h2

`endif

// ---- sim/serial_line_arbiter_bit_timer_bench.sv ----
// bench for the arbiter timer: bus tasks and one task per scenario
`include "sla_defines.vh"
module serial_line_arbiter_bit_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] CT = `SLA_ADDR_CTRL;
  localparam logic [3:0] CN = `SLA_ADDR_COUNT;
  localparam logic [3:0] ST = `SLA_ADDR_IRQ_STAT;
  localparam logic [3:0] MK = `SLA_ADDR_IRQ_MASK;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] awAddr = 4'h0;
  logic [3:0] arAddr = 4'h0;
  logic [31:0] wData = 32'h0;
  logic awValid = 1'b0;
  logic wValid = 1'b0;
  logic bReady = 1'b0;
  logic arValid = 1'b0;
  logic rReady = 1'b0;
  logic txIn = 1'b1;
  logic pSel = 1'b0;
  logic bTick = 1'b0;
  logic oTick = 1'b0;
  logic dom = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid, txd, irq, rxd;
  logic [31:0] rData, d;
  int n_errors = 0;
  int tests_run = 0;
  int e;
  time t0;
  always #10 clock = ~clock;
  // bus-fed ticks every cycle, oscillator-fed every other one, so the source shows
  always @(posedge clock)
  begin
    bTick <= arst_n;
    oTick <= ~oTick & arst_n;
  end
  sla_arbiter_timer u_dut (.clock(clock), .arst_n(arst_n), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .rxdIn(rxd), .internalTransmitOut(txIn),
    .prescalerSourceSelect(pSel), .busPrescalerTick(bTick), .oscPrescalerTick(oTick),
    .txdPin(txd), .irq(irq));
  sla_line_model u_line (.txdPin(txd), .dominant(dom), .rxd(rxd));
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    awAddr <= a;
    wData <= {24'h0, v};
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do
    begin
      @(posedge clock);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
    end
    while ((awValid && !awReady) || (wValid && !wReady));
    while (!bValid) @(posedge clock);
    bReady <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do @(posedge clock); while (!arReady);
    arValid <= 1'b0;
    do @(posedge clock); while (!rValid);
    d = rData;
    rReady <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x)
    begin
      n_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic chkr(input logic [31:0] g, input int lo, input int hi);
    tests_run++;
    if ($isunknown(g) || g < lo || g > hi)
    begin
      n_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, g, lo);
    end
  endtask
  task automatic er(input logic [3:0] a, input logic [31:0] x);
    rd(a);
    chk(d, x);
  endtask
  task automatic s_idle;
    er(CT, 32'h0);
    er(CN, 32'h0);
    er(MK, 32'h0);
    for (int m = 0; m < 2; m++)
    begin
      wr(CT, m ? 8'hC0 : 8'h00);
      dom <= 1'b1;
      cyc(20);
      dom <= 1'b0;
      er(CT, m ? 32'hC0 : 32'h0);
      er(CN, 32'h0);
    end
  endtask
  task automatic s_measure;
    wr(CT, 8'h40);
    cyc(4);
    dom <= 1'b1;
    t0 = $time;
    cyc(100);
    dom <= 1'b0;
    er(CT, 32'h44);
    cyc(50);
    dom <= 1'b1;
    e = ($time - t0) / 80;
    cyc(4);
    dom <= 1'b0;
    er(CT, 32'h48);
    rd(CN);
    chkr(d, e - 1, e + 1);
    er(ST, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(MK, 8'h01);
    chk({31'h0, irq}, 32'h1);
    wr(ST, 8'h01);
    chk({31'h0, irq}, 32'h0);
    wr(CT, 8'h40);
    er(CT, 32'h40);
    er(CN, 32'h0);
  endtask
  task automatic s_overflow;
    dom <= 1'b1;
    t0 = $time;
    cyc(2100);
    dom <= 1'b0;
    cyc(4);
    dom <= 1'b1;
    e = ($time - t0) / 80 - 512;
    cyc(4);
    dom <= 1'b0;
    er(CT, 32'h4A);
    rd(CN);
    chkr(d, e - 1, e + 1);
    er(ST, 32'h3);
    wr(ST, 8'h03);
  endtask
  task automatic s_break;
    dom <= 1'b1;
    pSel <= 1'b1;
    wr(CT, 8'h50);
    t0 = $time;
    cyc(160);
    dom <= 1'b0;
    e = ($time - t0) / 160;
    er(CT, 32'h58);
    rd(CN);
    chkr(d, e - 2, e + 1);
    er(ST, 32'h1);
    wr(ST, 8'h01);
    pSel <= 1'b0;
  endtask
  task automatic s_arb;
    wr(CT, 8'h80);
    txIn <= 1'b0;
    cyc(4);
    txIn <= 1'b1;
    dom <= 1'b1;
    cyc(200);
    er(CT, 32'h84);
    cyc(40);
    txIn <= 1'b0;
    cyc(2);
    chk({31'h0, txd}, 32'h1);
    er(CT, 32'hA0);
    er(ST, 32'h4);
    wr(CT, 8'h00);
    chk({31'h0, txd}, 32'h0);
    dom <= 1'b0;
    wr(CT, 8'h80);
    txIn <= 1'b1;
    cyc(300);
    er(CT, 32'h84);
    txIn <= 1'b0;
    cyc(2);
    txIn <= 1'b1;
    t0 = $time;
    cyc(100);
    e = ($time - t0) / 80;
    rd(CN);
    chkr(d, e - 1, e + 1);
    txIn <= 1'b0;
    cyc(3);
    er(CN, 32'h0);
    er(CT, 32'h80);
  endtask
  task automatic s_arb_pre;
    wr(CT, 8'h90);
    txIn <= 1'b1;
    dom <= 1'b1;
    cyc(20);
    er(CT, 32'h94);
    cyc(20);
    er(CT, 32'hB0);
    wr(CT, 8'h00);
    dom <= 1'b0;
  endtask
  task automatic final_report;
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    s_idle();
    s_measure();
    s_overflow();
    s_break();
    s_arb();
    s_arb_pre();
    final_report();
  end
  // whole sequence is near 3300 cycles; this allows more than twice that
  initial
  begin
    #200us;
    n_errors++;
    final_report();
  end
endmodule // serial_line_arbiter_bit_timer_bench

// ---- sim/sla_arbiter_timer_sva.sv ----
// bus handshake and transmit pin checks for the arbiter timer
module sla_arbiter_timer_sva (
  input wire clock, // clock
  input wire arst_n, // reset
  input wire s_axi_awvalid, // aw valid
  input wire s_axi_awready, // aw ready
  input wire s_axi_wvalid, // w valid
  input wire s_axi_wready, // w ready
  input wire [1:0] s_axi_bresp, // b resp
  input wire s_axi_bvalid, // b valid
  input wire s_axi_bready, // b ready
  input wire s_axi_arvalid, // ar valid
  input wire s_axi_arready, // ar ready
  input wire [31:0] s_axi_rdata, // r data
  input wire [1:0] s_axi_rresp, // r resp
  input wire s_axi_rvalid, // r valid
  input wire s_axi_rready, // r ready
  input wire internalTransmitOut, // serial module level
  input wire txdPin // pin level
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read answer changed early");
  property p_b_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_b_ans: assert property (p_b_ans)
    else $error("write response late");
  property p_r_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_ans: assert property (p_r_ans)
    else $error("read answer late");
  property p_b_okay;
    s_axi_bvalid |-> s_axi_bresp == 2'h0;
  endproperty
  a_b_okay: assert property (p_b_okay)
    else $error("write response not okay");
  property p_r_okay;
    s_axi_rvalid |-> s_axi_rresp == 2'h0;
  endproperty
  a_r_okay: assert property (p_r_okay)
    else $error("read response not okay");
  property p_ar_rdy;
    s_axi_arready == !s_axi_rvalid;
  endproperty
  a_ar_rdy: assert property (p_ar_rdy)
    else $error("read address ready wrong");
  property p_aw_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_block: assert property (p_aw_block)
    else $error("write taken during response");
  property p_r_width;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_r_width: assert property (p_r_width)
    else $error("upper read bits set");
  property p_txd;
    !txdPin |-> !internalTransmitOut;
  endproperty
  a_txd: assert property (p_txd)
    else $error("pin low while transmit high");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
  c_forced: cover property (txdPin && !internalTransmitOut);
endmodule // sla_arbiter_timer_sva

bind sla_arbiter_timer sla_arbiter_timer_sva u_sva (.clock(clock), .arst_n(arst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .internalTransmitOut(internalTransmitOut), .txdPin(txdPin));

// ---- sim/sla_line_model.sv ----
// shared serial line: wired-and of our pin and another sender
module sla_line_model (
  input wire txdPin, // our pin level
  input wire dominant, // other sender pulls low
  output logic rxd // level seen on receive
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released line rests high, so only a dominant sender wins it
  assign rxd = txdPin & ~dominant;
endmodule // sla_line_model
